/* logic/vrpa_consts.svh */
`ifndef VRPA_CONSTS_SVH
`define VRPA_CONSTS_SVH

// ==========================================================================
// encodings of the coprocessor access
// ==========================================================================
`define VRPA_COPROC       4'hF
`define VRPA_RPR_OPC1     3'h0
`define VRPA_RPR_CRN      4'hC
`define VRPA_RPR_CRM      4'hB
`define VRPA_RPR_OPC2     3'h3
`define VRPA_ICH_OPC1     3'h4
`define VRPA_ICH_CRN      4'hC
`define VRPA_AP0_CRM      4'h8
`define VRPA_AP1_CRM      4'h9
`define VRPA_CTL_CRM      4'hB
`define VRPA_LR_CRM_LO    4'hC
`define VRPA_LR_CRM_HI    4'hF

// ==========================================================================
// control/status selectors under the control CRm
// ==========================================================================
`define VRPA_SEL_HCR      3'h0
`define VRPA_SEL_VTR      3'h1
`define VRPA_SEL_MISR     3'h2
`define VRPA_SEL_EISR     3'h3
`define VRPA_SEL_ELRSR    3'h5
`define VRPA_SEL_VMCR     3'h7

// ==========================================================================
// fields, reset values, figures
// ==========================================================================
`define VRPA_PRIO_MSB     7
`define VRPA_GROUP_LSB    1
`define VRPA_IDLE_PRIO    8'hFF
`define VRPA_AP_RESET     32'h0000_0000
`define VRPA_EC_CP15      6'h03
`define VRPA_AP_REGS      4
`define VRPA_VTR_VALUE    32'h0000_0000

`endif

/* logic/vrpa_pkg.sv */
`default_nettype none

package vrpa_pkg;

  typedef enum logic [1:0] {
    VRPA_RES_OK    = 2'b00,
    VRPA_RES_UNDEF = 2'b01,
    VRPA_RES_TRAP2 = 2'b10,
    VRPA_RES_TRAP3 = 2'b11
  } vrpa_res_e;

  typedef enum logic [1:0] {
    VRPA_EL0 = 2'b00,
    VRPA_EL1 = 2'b01,
    VRPA_EL2 = 2'b10,
    VRPA_EL3 = 2'b11
  } vrpa_el_e;

  typedef enum logic [1:0] {
    VRPA_ST_IDLE = 2'b00,
    VRPA_ST_RESP = 2'b01
  } vrpa_state_e;

endpackage

`default_nettype wire

/* logic/vrpa_dec_if.sv */
`default_nettype none

// carries one decoded access between the decoder and the top
interface vrpa_dec_if;
  logic                hit_rpr;
  logic                hit_ap0;
  logic                hit_ich_ro;
  logic                hit_ich_rw;
  logic [1:0]          ap_idx;
  vrpa_pkg::vrpa_res_e res;
  logic                use_virt;

  modport dec (output hit_rpr, hit_ap0, hit_ich_ro, hit_ich_rw, ap_idx,
               res, use_virt);
  modport top (input hit_rpr, hit_ap0, hit_ich_ro, hit_ich_rw, ap_idx,
               res, use_virt);
endinterface

`default_nettype wire

/* logic/vrpa_decode.sv */
`include "vrpa_consts.svh"
`default_nettype none

module vrpa_decode (
  // access
  input  wire logic [3:0] coproc_in,
  input  wire logic [2:0] opc1_in,
  input  wire logic [3:0] crn_in,
  input  wire logic [3:0] crm_in,
  input  wire logic [2:0] opc2_in,
  input  wire logic       write_in,
  // state
  input  wire logic [1:0] el_in,
  input  wire logic [7:0] cfg_in,
  // result
  vrpa_dec_if.dec         dec
);
  // cfg_in: 0 el2_en 1 t12 2 sre1 3 tc 4 fmo 5 imo 6 el3 routes both
  //         7 el3 undef control
  logic el2_en;
  logic is_rpr;
  logic is_ich;
  logic is_ctl;
  logic ro_sel;

  assign el2_en = cfg_in[0];

  // ==========================================================================
  // encoding decode
  // ==========================================================================
  always_comb begin
    is_rpr = (coproc_in == `VRPA_COPROC) && (opc1_in == `VRPA_RPR_OPC1) &&
             (crn_in == `VRPA_RPR_CRN) && (crm_in == `VRPA_RPR_CRM) &&
             (opc2_in == `VRPA_RPR_OPC2);
    is_ich = (coproc_in == `VRPA_COPROC) && (opc1_in == `VRPA_ICH_OPC1) &&
             (crn_in == `VRPA_ICH_CRN);
    is_ctl = is_ich && (crm_in == `VRPA_CTL_CRM);
    ro_sel = (opc2_in == `VRPA_SEL_VTR) || (opc2_in == `VRPA_SEL_MISR) ||
             (opc2_in == `VRPA_SEL_EISR) || (opc2_in == `VRPA_SEL_ELRSR);
    dec.hit_rpr    = is_rpr;
    dec.hit_ap0    = is_ich && (crm_in == `VRPA_AP0_CRM) && !opc2_in[2];
    dec.hit_ich_ro = is_ctl && ro_sel;
    dec.hit_ich_rw = is_ich && !(is_ctl && ro_sel) &&
                     ((crm_in == `VRPA_AP0_CRM) ||
                      (crm_in == `VRPA_AP1_CRM) ||
                      (is_ctl && ((opc2_in == `VRPA_SEL_HCR) ||
                                  (opc2_in == `VRPA_SEL_VMCR))) ||
                      (crm_in >= `VRPA_LR_CRM_LO));
    dec.ap_idx     = opc2_in[1:0];
  end

  // ==========================================================================
  // privilege checks for the running priority read
  // ==========================================================================
  always_comb begin
    dec.res      = vrpa_pkg::VRPA_RES_OK;
    dec.use_virt = 1'b0;
    if (write_in) begin
      dec.res = vrpa_pkg::VRPA_RES_UNDEF;
    end else begin
      case (el_in)
        vrpa_pkg::VRPA_EL0: begin
          dec.res = vrpa_pkg::VRPA_RES_UNDEF;
        end
        vrpa_pkg::VRPA_EL1: begin
          if (cfg_in[6] && cfg_in[7]) begin
            dec.res = vrpa_pkg::VRPA_RES_UNDEF;
          end else if (el2_en && cfg_in[1]) begin
            dec.res = vrpa_pkg::VRPA_RES_TRAP2;
          end else if (!cfg_in[2]) begin
            dec.res = vrpa_pkg::VRPA_RES_UNDEF;
          end else if (el2_en && cfg_in[3]) begin
            dec.res = vrpa_pkg::VRPA_RES_TRAP2;
          end else if (el2_en && (cfg_in[4] || cfg_in[5])) begin
            dec.use_virt = 1'b1;
          end else if (cfg_in[6]) begin
            dec.res = vrpa_pkg::VRPA_RES_TRAP3;
          end
        end
        default: begin
          dec.res = vrpa_pkg::VRPA_RES_OK;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* logic/vrpa_ap_bank.sv */
`include "vrpa_consts.svh"
`default_nettype none

module vrpa_ap_bank (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        warm_rst_in,
  // access
  input  wire logic        wr_in,
  input  wire logic [1:0]  idx_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        el2_impl_in,
  // state
  output logic      [31:0] rdata_out,
  output logic             any_out,
  output logic      [6:0]  lowest_out
);
  logic [31:0] ap      [`VRPA_AP_REGS];
  logic [31:0] next_ap [`VRPA_AP_REGS];
  logic [127:0] flat;

  // ==========================================================================
  // storage
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < `VRPA_AP_REGS; g++) begin : g_ap
      always_comb begin
        next_ap[g] = ap[g];
        if (warm_rst_in) begin
          next_ap[g] = `VRPA_AP_RESET;
        end else if (wr_in && el2_impl_in && (idx_in == 2'(g))) begin
          next_ap[g] = wdata_in;
        end
      end
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          ap[g] <= `VRPA_AP_RESET;
        end else begin
          ap[g] <= next_ap[g];
        end
      end
      assign flat[g*32 +: 32] = ap[g];
    end
  endgenerate

  // lowest set bit is the highest active group priority
  always_comb begin
    lowest_out = 7'h7F;
    for (int i = 127; i >= 0; i--) begin
      if (flat[i]) begin
        lowest_out = i[6:0];
      end
    end
    any_out   = |flat;
    rdata_out = el2_impl_in ? ap[idx_in] : 32'h0000_0000;
  end

endmodule

`default_nettype wire

/* logic/vrpa_top.sv */
`include "vrpa_consts.svh"
`default_nettype none

module vrpa_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        warm_rst_in,
  // coprocessor access
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic [3:0]  coproc_in,
  input  wire logic [2:0]  opc1_in,
  input  wire logic [3:0]  crn_in,
  input  wire logic [3:0]  crm_in,
  input  wire logic [2:0]  opc2_in,
  input  wire logic [31:0] wdata_in,
  // processor state
  input  wire logic [1:0]  el_in,
  input  wire logic        el1_aa32_in,
  input  wire logic        el2_impl_in,
  input  wire logic        el2_enabled_in,
  input  wire logic        hyp_trap_coproc_group12_in,
  input  wire logic        sysreg_if_enable_el1_in,
  input  wire logic        sysreg_if_enable_el2_in,
  input  wire logic        sysreg_if_enable_el3_in,
  input  wire logic        trap_common_sysregs_in,
  input  wire logic        fiq_routing_override_in,
  input  wire logic        irq_routing_override_in,
  input  wire logic [1:0]  secure_irq_fiq_routing_in,
  input  wire logic        el3_undef_ctl_in,
  // priority sources
  input  wire logic [7:0]  physical_running_priority_in,
  // answer
  output logic             ack_out,
  output logic [31:0]      rdata_out,
  output logic             undef_out,
  output logic             trap_el2_out,
  output logic             trap_el3_out,
  output logic [5:0]       exc_class_out
);
  vrpa_dec_if          dif ();
  vrpa_pkg::vrpa_state_e state, next_state;
  logic [31:0]         next_rdata;
  logic                next_undef;
  logic                next_trap2;
  logic                next_trap3;
  logic [5:0]          next_ec;
  logic                next_ack;
  logic [7:0]          cfg;
  logic [31:0]         ap_rdata;
  logic                ap_any;
  logic [6:0]          ap_low;
  logic [7:0]          vrpr;
  logic [1:0]          ap_idx;
  logic                ap_wr;
  logic                el3_both;

  assign el3_both = &secure_irq_fiq_routing_in;
  assign cfg = {el3_undef_ctl_in, el3_both, irq_routing_override_in,
                fiq_routing_override_in, trap_common_sysregs_in,
                sysreg_if_enable_el1_in, hyp_trap_coproc_group12_in,
                el2_enabled_in};

  // ==========================================================================
  // decode and active priority store
  // ==========================================================================
  vrpa_decode u_dec (
    .coproc_in (coproc_in),
    .opc1_in   (opc1_in),
    .crn_in    (crn_in),
    .crm_in    (crm_in),
    .opc2_in   (opc2_in),
    .write_in  (write_in),
    .el_in     (el_in),
    .cfg_in    (cfg),
    .dec       (dif)
  );

  // layout of the group-0 words follows the memory-mapped form, one bit
  // per preemption level
  assign ap_idx = dif.ap_idx;
  assign ap_wr  = req_in && write_in && dif.hit_ap0 &&
                  (el_in[1] == 1'b1);

  vrpa_ap_bank u_ap (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .warm_rst_in (warm_rst_in),
    .wr_in       (ap_wr),
    .idx_in      (ap_idx),
    .wdata_in    (wdata_in),
    .el2_impl_in (el2_impl_in),
    .rdata_out   (ap_rdata),
    .any_out     (ap_any),
    .lowest_out  (ap_low)
  );

  // ==========================================================================
  // virtual running priority
  // ==========================================================================
  // a dropped interrupt leaves no active bit, so only set bits count
  always_comb begin
    if (ap_any) begin
      vrpr = {ap_low, 1'b0};
    end else begin
      vrpr = `VRPA_IDLE_PRIO;
    end
  end

  // ==========================================================================
  // answer
  // ==========================================================================
  always_comb begin
    next_state = vrpa_pkg::VRPA_ST_IDLE;
    next_rdata = 32'h0000_0000;
    next_undef = 1'b0;
    next_trap2 = 1'b0;
    next_trap3 = 1'b0;
    next_ec    = 6'h00;
    next_ack   = 1'b0;
    if (req_in) begin
      next_state = vrpa_pkg::VRPA_ST_RESP;
      next_ack   = 1'b1;
      if (dif.hit_rpr) begin
        if (!(el1_aa32_in && el2_impl_in)) begin
          next_undef = 1'b1;
        // EL2 checks its own enable before the monitor routing; with the
        // undefined control set both orders end undefined anyway
        end else if (el_in == vrpa_pkg::VRPA_EL2 &&
                     !write_in && !sysreg_if_enable_el2_in) begin
          next_undef = 1'b1;
        end else if (el_in == vrpa_pkg::VRPA_EL2 && !write_in &&
                     el3_both) begin
          next_undef = el3_undef_ctl_in;
          next_trap3 = !el3_undef_ctl_in;
          next_ec    = el3_undef_ctl_in ? 6'h00 : `VRPA_EC_CP15;
        end else if (el_in == vrpa_pkg::VRPA_EL3 && !write_in) begin
          next_undef = !sysreg_if_enable_el3_in;
          next_rdata = sysreg_if_enable_el3_in ?
                       {24'h00_0000, physical_running_priority_in} :
                       32'h0000_0000;
        end else begin
          case (dif.res)
            vrpa_pkg::VRPA_RES_UNDEF: begin
              next_undef = 1'b1;
            end
            vrpa_pkg::VRPA_RES_TRAP2: begin
              next_trap2 = 1'b1;
              next_ec    = `VRPA_EC_CP15;
            end
            vrpa_pkg::VRPA_RES_TRAP3: begin
              next_trap3 = 1'b1;
              next_ec    = `VRPA_EC_CP15;
            end
            default: begin
              next_rdata = dif.use_virt ? {24'h00_0000, vrpr} :
                           {24'h00_0000,
                            physical_running_priority_in};
            end
          endcase
        end
      end else if (dif.hit_ap0) begin
        if (el_in[1] == 1'b0) begin
          next_undef = 1'b1;
        end else if (!write_in) begin
          next_rdata = ap_rdata;
        end
      end else if (dif.hit_ich_ro) begin
        next_undef = write_in;
        next_rdata = `VRPA_VTR_VALUE;
      end else if (!dif.hit_ich_rw) begin
        next_undef = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state         <= vrpa_pkg::VRPA_ST_IDLE;
      ack_out       <= 1'b0;
      rdata_out     <= 32'h0000_0000;
      undef_out     <= 1'b0;
      trap_el2_out  <= 1'b0;
      trap_el3_out  <= 1'b0;
      exc_class_out <= 6'h00;
    end else begin
      state         <= next_state;
      ack_out       <= next_ack;
      rdata_out     <= next_rdata;
      undef_out     <= next_undef;
      trap_el2_out  <= next_trap2;
      trap_el3_out  <= next_trap3;
      exc_class_out <= next_ec;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // legal read of the register on a part that provides it; the
  // virtual form is the EL1 read that a routing override takes
  logic rpr_rd;
  logic el1_virt_rd;

  assign rpr_rd      = req_in && dif.hit_rpr && !write_in &&
                       el1_aa32_in && el2_impl_in;
  assign el1_virt_rd = rpr_rd && (el_in == vrpa_pkg::VRPA_EL1) &&
                       dif.use_virt &&
                       (dif.res == vrpa_pkg::VRPA_RES_OK);

  // answer timing and outcome
  ack_next_a: assert property (req_in |=> ack_out &&
      state == vrpa_pkg::VRPA_ST_RESP) else $error("request not answered");
  ack_pulse_a: assert property (!req_in |=> !ack_out)
    else $error("answer without request");
  one_result_a: assert property ($onehot0({undef_out, trap_el2_out,
      trap_el3_out})) else $error("more than one outcome");
  ec_code_a: assert property (trap_el2_out || trap_el3_out |->
      exc_class_out == `VRPA_EC_CP15) else $error("trap class wrong");

  // readout
  rsvd_zero_a: assert property (req_in && dif.hit_rpr |=>
      rdata_out[31:8] == 24'h00_0000) else $error("reserved bits not zero");
  virt_sel_a: assert property (el1_virt_rd |=>
      rdata_out[7:0] == $past(vrpr)) else $error("virtual priority lost");
  idle_prio_a: assert property (el1_virt_rd && !ap_any |=>
      rdata_out[7:0] == `VRPA_IDLE_PRIO) else $error("idle priority wrong");
  group_lsb_a: assert property (el1_virt_rd && ap_any |=>
      !rdata_out[0]) else $error("group priority lsb set");
  el1_phys_a: assert property (rpr_rd && el_in == 2'b01 &&
      !el2_enabled_in && !el3_both && sysreg_if_enable_el1_in |=>
      rdata_out[7:0] == $past(physical_running_priority_in))
    else $error("el1 physical wrong");
  el3_phys_a: assert property (rpr_rd && el_in == 2'b11 &&
      sysreg_if_enable_el3_in |=>
      rdata_out[7:0] == $past(physical_running_priority_in))
    else $error("el3 physical wrong");

  // privilege and presence
  el0_undef_a: assert property (req_in && dif.hit_rpr &&
      el_in == 2'b00 |=> undef_out) else $error("el0 not undef");
  t12_trap_a: assert property (rpr_rd && el_in == 2'b01 &&
      !el3_both && el2_enabled_in && hyp_trap_coproc_group12_in
      |=> trap_el2_out && exc_class_out == 6'h03)
    else $error("t12 trap missing");
  sre1_undef_a: assert property (rpr_rd && el_in == 2'b01 &&
      !el3_both && !hyp_trap_coproc_group12_in && !sysreg_if_enable_el1_in
      |=> undef_out && !trap_el2_out) else $error("sre1 not undef");
  el2_trap3_a: assert property (rpr_rd && el_in == 2'b10 &&
      sysreg_if_enable_el2_in && el3_both && !el3_undef_ctl_in
      |=> trap_el3_out) else $error("el2 monitor trap missing");
  el3_sre_a: assert property (rpr_rd && el_in == 2'b11 &&
      !sysreg_if_enable_el3_in |=> undef_out) else $error("el3 sre");
  absent_a: assert property (req_in && dif.hit_rpr && !el2_impl_in
      |=> undef_out) else $error("absent register defined");
  rpr_write_a: assert property (req_in && dif.hit_rpr && write_in
      |=> undef_out) else $error("running priority write accepted");
  ro_write_a: assert property (req_in && dif.hit_ich_ro && write_in
      |=> undef_out) else $error("read-only register written");
  ich_rw_a: assert property (req_in && dif.hit_ich_rw && !dif.hit_ap0
      |=> !undef_out) else $error("control register refused");

  // active priority store
  ap_zero_a: assert property (!el2_impl_in |-> ap_rdata == 32'h0)
    else $error("ap nonzero without el2");
  warm_clr_a: assert property (warm_rst_in |=> !ap_any)
    else $error("warm reset kept bits");
  ap_land_a: assert property (ap_wr && el2_impl_in &&
      !warm_rst_in && wdata_in != 32'h0 |=> ap_any)
    else $error("active bit lost");

  cov_virt_c:  cover property (ack_out && !undef_out && vrpr != 8'hFF);
  cov_trap2_c: cover property (trap_el2_out);
  cov_trap3_c: cover property (trap_el3_out);
  cov_undef_c: cover property (undef_out);
  cov_apwr_c:  cover property (ap_wr && el2_impl_in);

endmodule

`default_nettype wire

/* verif/vrpa_core_model.sv */
`default_nettype none

// ==========================================================================
// processor core side: issues coprocessor accesses
// ==========================================================================
module vrpa_core_model (
  // clock
  input  wire logic        clk_in,
  // request
  output logic             req_out,
  output logic             write_out,
  output logic [3:0]       coproc_out,
  output logic [2:0]       opc1_out,
  output logic [3:0]       crn_out,
  output logic [3:0]       crm_out,
  output logic [2:0]       opc2_out,
  output logic [31:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    coproc_out = 4'h0;
    opc1_out = 3'h0;
    crn_out = 4'h0;
    crm_out = 4'h0;
    opc2_out = 3'h0;
    wdata_out = 32'h0;
  end

  // single-cycle request; afterwards the fields flip so that a stale
  // encoding can never pass for a fresh one
  task automatic issue(input logic wr, input logic [2:0] o1,
                       input logic [3:0] crm, input logic [2:0] o2,
                       input logic [31:0] wd);
    @(posedge clk_in);
    req_out    <= 1'b1;
    write_out  <= wr;
    coproc_out <= 4'hF;
    opc1_out   <= o1;
    crn_out    <= 4'hC;
    crm_out    <= crm;
    opc2_out   <= o2;
    wdata_out  <= wd;
    @(posedge clk_in);
    req_out    <= 1'b0;
    write_out  <= ~wr;
    coproc_out <= 4'h0;
    opc1_out   <= ~o1;
    crn_out    <= 4'h3;
    crm_out    <= ~crm;
    opc2_out   <= ~o2;
    wdata_out  <= ~wd;
  endtask
endmodule

`default_nettype wire

/* verif/test_virtual_running_priority_access.sv */
`default_nettype none

module test_virtual_running_priority_access;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // state word: [14:13] el, 12 aa32, 11 el2 impl, 10 el2 enabled, 9 t12,
  // 8..6 if enables el1..el3, 5 tc, 4 fiq ovr, 3 irq ovr, [2:1] el3 routing,
  // 0 el3 undef control; each scenario flips bits of the base
  // ========================================================================
  localparam logic [14:0] BASE = 15'h3DD0;
  localparam logic [14:0] M_EL0 = 15'h2000, M_EL2 = 15'h6000;
  localparam logic [14:0] M_EL3 = 15'h4000, M_AA32 = 15'h1000;
  localparam logic [14:0] M_IMPL = 15'h0800, M_EN2 = 15'h0400;
  localparam logic [14:0] M_T12 = 15'h0200, M_SRE1 = 15'h0100;
  localparam logic [14:0] M_SRE2 = 15'h0080, M_SRE3 = 15'h0040;
  localparam logic [14:0] M_TC = 15'h0020, M_FMO = 15'h0010;
  localparam logic [14:0] M_IMO = 15'h0008, M_SCR = 15'h0006;
  localparam logic [14:0] M_UDEF = 15'h0001;
  localparam vrpa_pkg::vrpa_res_e OK = vrpa_pkg::VRPA_RES_OK;
  localparam vrpa_pkg::vrpa_res_e UNDF = vrpa_pkg::VRPA_RES_UNDEF;
  localparam vrpa_pkg::vrpa_res_e TRP2 = vrpa_pkg::VRPA_RES_TRAP2;
  localparam vrpa_pkg::vrpa_res_e TRP3 = vrpa_pkg::VRPA_RES_TRAP3;
  localparam logic [2:0] RO_SEL [4] = '{3'h1, 3'h2, 3'h3, 3'h5};

  logic        clk_in;
  logic        nrst_in;
  logic        warm_rst;
  logic [14:0] st;
  logic        req;
  logic        wr;
  logic [3:0]  coproc;
  logic [2:0]  opc1;
  logic [3:0]  crn;
  logic [3:0]  crm;
  logic [2:0]  opc2;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        undef;
  logic        trap2;
  logic        trap3;
  logic [5:0]  ec;
  int          miscompares;
  int          check_count;

  vrpa_core_model u_vrpa_core_model (
    .clk_in(clk_in), .req_out(req), .write_out(wr), .coproc_out(coproc),
    .opc1_out(opc1), .crn_out(crn), .crm_out(crm), .opc2_out(opc2),
    .wdata_out(wdata)
  );

  vrpa_top u_vrpa_top (
    .clk_in(clk_in), .nrst_in(nrst_in), .warm_rst_in(warm_rst),
    .req_in(req), .write_in(wr), .coproc_in(coproc), .opc1_in(opc1),
    .crn_in(crn), .crm_in(crm), .opc2_in(opc2), .wdata_in(wdata),
    .el_in(st[14:13]), .el1_aa32_in(st[12]), .el2_impl_in(st[11]),
    .el2_enabled_in(st[10]), .hyp_trap_coproc_group12_in(st[9]),
    .sysreg_if_enable_el1_in(st[8]), .sysreg_if_enable_el2_in(st[7]),
    .sysreg_if_enable_el3_in(st[6]), .trap_common_sysregs_in(st[5]),
    .fiq_routing_override_in(st[4]), .irq_routing_override_in(st[3]),
    .secure_irq_fiq_routing_in(st[2:1]), .el3_undef_ctl_in(st[0]),
    .physical_running_priority_in(8'h55),
    .ack_out(ack), .rdata_out(rdata), .undef_out(undef),
    .trap_el2_out(trap2), .trap_el3_out(trap3), .exc_class_out(ec)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ========================================================================
  // checking and access tasks
  // ========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // answer is sampled 1 ns after the edge that takes the request
  task automatic acc(input logic [14:0] m, input logic w,
                     input logic [2:0] o1, input logic [3:0] cm,
                     input logic [2:0] o2, input logic [31:0] wd,
                     input vrpa_pkg::vrpa_res_e res,
                     input logic [31:0] exp);
    logic [2:0] fl;
    @(posedge clk_in);
    st <= BASE ^ m;
    #1;
    chk({31'h0, ack}, 32'h0);
    u_vrpa_core_model.issue(w, o1, cm, o2, wd);
    #1;
    fl = (res == UNDF) ? 3'h4 : (res == TRP2) ? 3'h2 :
         (res == TRP3) ? 3'h1 : 3'h0;
    chk({31'h0, ack}, 32'h1);
    chk({29'h0, undef, trap2, trap3}, {29'h0, fl});
    chk({26'h0, ec}, (fl[1] | fl[0]) ? 32'h3 : 32'h0);
    if (res == OK && !w)
      chk(rdata, exp);
  endtask

  task automatic rpr(input logic [14:0] m, input vrpa_pkg::vrpa_res_e res,
                     input logic [7:0] pr);
    acc(m, 1'b0, 3'h0, 4'hB, 3'h3, 32'h0, res, {24'h0, pr});
  endtask

  task automatic apw(input logic [14:0] m, input logic [1:0] n,
                     input logic [31:0] wd);
    acc(m, 1'b1, 3'h4, 4'h8, {1'b0, n}, wd, OK, 32'h0);
  endtask

  initial begin
    #20000;
    miscompares++;
    complete_run;
  end

  // ========================================================================
  // scenarios
  // ========================================================================
  initial begin
    miscompares = 0;
    check_count = 0;
    nrst_in = 1'b0;
    warm_rst = 1'b0;
    st = BASE;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    rpr(15'h0, OK, 8'hFF);
    rpr(M_FMO | M_IMO, OK, 8'hFF);
    rpr(M_FMO, OK, 8'h55);
    rpr(M_EN2, OK, 8'h55);
    rpr(M_EL0, UNDF, 8'h0);
    rpr(M_T12, TRP2, 8'h0);
    rpr(M_T12 | M_EN2, OK, 8'h55);
    rpr(M_SRE1 | M_TC, UNDF, 8'h0);
    rpr(M_TC, TRP2, 8'h0);
    rpr(M_FMO | M_SCR, TRP3, 8'h0);
    rpr(M_FMO | M_SCR | M_UDEF, UNDF, 8'h0);
    rpr(M_SCR | M_UDEF, UNDF, 8'h0);
    rpr(M_EL2, OK, 8'h55);
    rpr(M_EL2 | M_SCR, TRP3, 8'h0);
    rpr(M_EL2 | M_SRE2, UNDF, 8'h0);
    rpr(M_EL3 | M_SCR, OK, 8'h55);
    rpr(M_EL3 | M_SRE3, UNDF, 8'h0);
    rpr(M_AA32, UNDF, 8'h0);
    rpr(M_IMPL, UNDF, 8'h0);
    acc(15'h0, 1'b1, 3'h0, 4'hB, 3'h3, 32'h0, UNDF, 32'h0);
    acc(15'h0, 1'b0, 3'h0, 4'hB, 3'h2, 32'h0, UNDF, 32'h0);
    acc(15'h0, 1'b0, 3'h1, 4'hB, 3'h3, 32'h0, UNDF, 32'h0);
    // active priorities drive the virtual readout
    acc(M_EL2, 1'b0, 3'h4, 4'h8, 3'h0, 32'h0, OK, 32'h0);
    apw(M_EL2, 2'h0, 32'h0000_0020);
    apw(M_EL2, 2'h2, 32'h0000_0001);
    acc(M_EL2, 1'b0, 3'h4, 4'h8, 3'h0, 32'h0, OK, 32'h20);
    rpr(15'h0, OK, 8'h0A);
    rpr(M_FMO | M_IMO, OK, 8'h0A);
    apw(M_EL2, 2'h0, 32'h0);
    rpr(15'h0, OK, 8'h80);
    apw(M_EL3, 2'h2, 32'h0);
    apw(M_EL3, 2'h3, 32'h8000_0000);
    rpr(15'h0, OK, 8'hFE);
    acc(15'h0, 1'b0, 3'h4, 4'h8, 3'h0, 32'h0, UNDF, 32'h0);
    @(posedge clk_in);
    warm_rst <= 1'b1;
    @(posedge clk_in);
    warm_rst <= 1'b0;
    rpr(15'h0, OK, 8'hFF);
    acc(M_EL2, 1'b0, 3'h4, 4'h8, 3'h3, 32'h0, OK, 32'h0);
    apw(M_EL3 | M_IMPL, 2'h0, 32'h0000_0020);
    acc(M_EL3 | M_IMPL, 1'b0, 3'h4, 4'h8, 3'h0, 32'h0, OK, 32'h0);
    acc(M_EL2, 1'b0, 3'h4, 4'h8, 3'h0, 32'h0, OK, 32'h0);
    // control and list registers
    acc(M_EL2, 1'b0, 3'h4, 4'hB, 3'h7, 32'h0, OK, 32'h0);
    acc(M_EL2, 1'b1, 3'h4, 4'hB, 3'h0, 32'h1, OK, 32'h0);
    acc(M_EL2, 1'b0, 3'h4, 4'hB, 3'h1, 32'h0, OK, 32'h0);
    for (int i = 0; i < 4; i++)
      acc(M_EL2, 1'b1, 3'h4, 4'hB, RO_SEL[i], 32'h1, UNDF, 32'h0);
    for (int c = 12; c < 16; c++)
      acc(M_EL2, 1'b1, 3'h4, c[3:0], 3'h0, 32'h1, OK, 32'h0);
    acc(M_EL2, 1'b0, 3'h4, 4'hA, 3'h0, 32'h0, UNDF, 32'h0);
    complete_run;
  end
endmodule

`default_nettype wire
